// file: see_slave.sv
// Serial EEPROM two-wire slave: conditions, addressing, ack, read, byte write
module see_slave #(
  parameter int PU_CYC = see_pkg::PU_DELAY_CYC,
  parameter int WR_CYC = see_pkg::WR_TIME_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  see_bus_if.slave        bus,
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_protect,
  output logic            ready,
  output logic            write_busy
);
  logic scl_f, sda_f;
  see_filter u_scl (.clk(clk), .reset_n(reset_n), .din(bus.scl), .dout(scl_f));
  see_filter u_sda (.clk(clk), .reset_n(reset_n), .din(bus.sda), .dout(sda_f));
  logic wp_s1_reg, wp_reg;
  logic [7:0] mem_reg [see_pkg::MEM_DEPTH];
  see_pkg::see_state_t state_reg, state_next;
  logic scl_d_reg, sda_d_reg;
  logic [3:0]  bit_reg, bit_next;
  logic [7:0]  sh_reg, sh_next;
  logic [2:0]  upper_array_address_bits_reg, upper_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        pend_reg, pend_next, wpl_reg, wpl_next, rd_reg, rd_next;
  logic        drive_reg, drive_next, rdy_reg, rdy_next, busy_reg, busy_next;
  logic [31:0] pu_cnt_reg, pu_next, wr_cnt_reg, wr_next;
  logic        rise, fall, start_c, stop_c, commit;
  logic [7:0]  byte_in;
  logic [10:0] full_addr;
  assign rise    = scl_f & ~scl_d_reg;
  assign fall    = ~scl_f & scl_d_reg;
  assign start_c = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop_c  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  assign byte_in = {sh_reg[6:0], sda_f};
  assign full_addr = {upper_array_address_bits_reg, ptr_reg};
  always_comb begin
    state_next = state_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    upper_next = upper_array_address_bits_reg;
    ptr_next   = ptr_reg;
    wdata_next = wdata_reg;
    pend_next  = pend_reg;
    wpl_next   = wpl_reg;
    rd_next    = rd_reg;
    drive_next = drive_reg;
    busy_next  = busy_reg;
    rdy_next   = rdy_reg;
    commit     = 1'b0;
    pu_next    = pu_cnt_reg;
    wr_next    = wr_cnt_reg;
    if (!rdy_reg) begin
      pu_next = pu_cnt_reg + 32'h1;
      if (pu_cnt_reg == 32'(PU_CYC - 1)) rdy_next = 1'b1;
    end
    if (busy_reg) begin
      wr_next = wr_cnt_reg + 32'h1;
      if (wr_cnt_reg == 32'(WR_CYC - 1)) begin
        busy_next = 1'b0;
        commit    = 1'b1;
      end
    end
    if (!rdy_reg) begin
      state_next = see_pkg::SEE_IDLE;
    end else if (start_c || stop_c) begin
      bit_next   = 4'h0;
      drive_next = 1'b0;
      state_next = start_c ? see_pkg::SEE_DADDR : see_pkg::SEE_IDLE;
      if (stop_c && pend_reg && !busy_reg) begin
        busy_next = 1'b1;
        wr_next   = 32'h0;
      end
      pend_next = 1'b0;
    end else if (state_reg != see_pkg::SEE_IDLE) begin
      if (rise) begin
        bit_next = bit_reg + 4'h1;
        if (bit_reg < 4'h8) begin
          if (state_reg == see_pkg::SEE_RDATA) sh_next = {sh_reg[6:0], 1'b1};
          else                                 sh_next = byte_in;
        end
        // Master ack on the ninth clock fetches the next byte, no-ack ends the read
        if (bit_reg == 4'h8 && state_reg == see_pkg::SEE_RACK) begin
          if (sda_f) begin
            state_next = see_pkg::SEE_SKIP;
          end else begin
            ptr_next   = ptr_reg + 8'h1;
            sh_next    = mem_reg[4'(ptr_reg + 8'h1)];
            state_next = see_pkg::SEE_RDATA;
          end
        end
        if (bit_reg == 4'h7) begin
          unique case (state_reg)
            see_pkg::SEE_DADDR: begin
              if (byte_in[7:4] == see_pkg::TYPE_NIBBLE &&
                  ((byte_in[3:1] ^ device_select_pins) & ~see_pkg::SEL_MASK) == 3'h0 &&
                  !(busy_reg && !byte_in[0])) begin
                upper_next = byte_in[3:1] & see_pkg::SEL_MASK;
                rd_next    = byte_in[0];
              end else begin
                state_next = see_pkg::SEE_SKIP;
              end
            end
            see_pkg::SEE_WDATA: wdata_next = byte_in;
            default: ;
          endcase
        end
      end
      if (fall) begin
        if (bit_reg == 4'h8) begin
          drive_next = 1'b0;
          unique case (state_reg)
            see_pkg::SEE_DADDR: begin
              drive_next = 1'b1;
              state_next = rd_reg ? see_pkg::SEE_RDATA : see_pkg::SEE_BADDR;
              if (rd_reg) begin
                sh_next = busy_reg ? see_pkg::ERASED_BYTE : mem_reg[full_addr[3:0]];
              end
            end
            see_pkg::SEE_BADDR: begin
              drive_next = 1'b1;
              ptr_next   = sh_reg;
              state_next = see_pkg::SEE_WDATA;
            end
            see_pkg::SEE_WDATA: begin
              if (!wpl_reg) begin
                drive_next = 1'b1;
                pend_next  = 1'b1;
              end else begin
                state_next = see_pkg::SEE_SKIP;
              end
            end
            see_pkg::SEE_RDATA: state_next = see_pkg::SEE_RACK;
            default: ;
          endcase
        end else if (bit_reg == 4'h9) begin
          bit_next   = 4'h0;
          drive_next = 1'b0;
          // First bit of a read byte goes out after the ack clock falls
          if (state_reg == see_pkg::SEE_RDATA) drive_next = ~sh_reg[7];
          // Write-protect strobed on the fall just before the first data byte
          if (state_reg == see_pkg::SEE_WDATA && !pend_reg) wpl_next = wp_reg;
        end else if (state_reg == see_pkg::SEE_RDATA && bit_reg < 4'h8) begin
          drive_next = ~sh_reg[7];
        end
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= see_pkg::SEE_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h0;
      upper_array_address_bits_reg <= 3'h0;
      ptr_reg   <= 8'h0;
      wdata_reg <= 8'h0;
      pend_reg  <= 1'b0;
      wpl_reg   <= 1'b0;
      rd_reg    <= 1'b0;
      drive_reg <= 1'b0;
      busy_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
      pu_cnt_reg <= 32'h0;
      wr_cnt_reg <= 32'h0;
      wp_s1_reg <= 1'b0;
      wp_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      upper_array_address_bits_reg <= upper_next;
      ptr_reg   <= ptr_next;
      wdata_reg <= wdata_next;
      pend_reg  <= pend_next;
      wpl_reg   <= wpl_next;
      rd_reg    <= rd_next;
      drive_reg <= drive_next;
      busy_reg  <= busy_next;
      rdy_reg   <= rdy_next;
      pu_cnt_reg <= pu_next;
      wr_cnt_reg <= wr_next;
      wp_s1_reg <= write_protect;
      wp_reg    <= wp_s1_reg;
    end
  end
  // Memory array, written only when the internal write completes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < see_pkg::MEM_DEPTH; i++) mem_reg[i] <= see_pkg::ERASED_BYTE;
    end else if (commit) begin
      mem_reg[full_addr[3:0]] <= wdata_reg;
    end
  end
  assign bus.sda_s_o    = 1'b0;
  assign bus.sda_s_oe_n = ~drive_reg;
  assign ready          = rdy_reg;
  assign write_busy     = busy_reg;
endmodule

// file: see_pkg.sv
// Shared constants and types for the serial EEPROM bus slave and its master
package see_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          GLITCH_NS       = 100;
  localparam int          GLITCH_CYC      = GLITCH_NS / CLK_PERIOD_NS;
  localparam int          WR_TIME_MS      = 5;
  localparam int          WR_TIME_CYC     = WR_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          PU_DELAY_MS     = 1;
  localparam int          PU_DELAY_CYC    = PU_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          SCL_HALF_CYC    = 250;
  localparam logic [3:0]  TYPE_NIBBLE     = 4'ha;
  localparam int          MEM_ADDR_W      = 11;
  localparam int          MEM_DEPTH       = 16;
  localparam logic [2:0]  SEL_MASK        = 3'h0;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  typedef enum logic [2:0] {
    SEE_IDLE  = 3'b000,
    SEE_DADDR = 3'b001,
    SEE_BADDR = 3'b011,
    SEE_WDATA = 3'b010,
    SEE_RDATA = 3'b110,
    SEE_RACK  = 3'b111,
    SEE_SKIP  = 3'b101
  } see_state_t;
  typedef enum logic [2:0] {
    SEM_IDLE  = 3'b000,
    SEM_START = 3'b001,
    SEM_BIT   = 3'b011,
    SEM_ACK   = 3'b010,
    SEM_STOP  = 3'b110
  } see_mstate_t;
endpackage

// file: see_bus_if.sv
// Two-wire bus between the EEPROM slave and its bus master
interface see_bus_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  // Open-drain wired-AND with pull-ups
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);
  modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe_n);
  modport master (input scl, input sda, output scl_o, output scl_oe_n,
                  output sda_m_o, output sda_m_oe_n);
endinterface

// file: see_filter.sv
// Two-flop synchroniser followed by a glitch filter for one bus line
module see_filter (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  logic       s1_reg, s2_reg, out_reg, out_next;
  logic [3:0] cnt_reg, cnt_next;
  always_comb begin
    out_next = out_reg;
    cnt_next = 4'h0;
    if (s2_reg != out_reg) begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_reg == 4'(see_pkg::GLITCH_CYC)) begin
        out_next = s2_reg;
        cnt_next = 4'h0;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      out_reg <= 1'b1;
      cnt_reg <= 4'h0;
    end else begin
      s1_reg  <= din;
      s2_reg  <= s1_reg;
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end
  assign dout = out_reg;
endmodule

// file: see_master.sv
// Two-wire bus master: byte-level START, byte, ack and STOP sequencer
module see_master (
  input  wire logic       clk,
  input  wire logic       reset_n,
  see_bus_if.master       bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack
);
  logic sda_s1_reg, sda_s2_reg;
  see_pkg::see_mstate_t st_reg, st_next;
  logic [8:0] div_reg, div_next;
  logic       phase_reg, phase_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic       scl_reg, scl_next, sda_reg, sda_next;
  logic       rd_reg, rd_next, nack_reg, nack_next, stop_reg, stop_next;
  logic       rv_reg, rv_next, ack_reg, ack_next, rdy_reg, rdy_next;
  logic       tick;
  assign tick = div_reg == 9'(see_pkg::SCL_HALF_CYC - 1);
  always_comb begin
    st_next = st_reg; div_next = tick ? 9'h0 : div_reg + 9'h1;
    phase_next = phase_reg; bit_next = bit_reg; sh_next = sh_reg;
    scl_next = scl_reg; sda_next = sda_reg; rd_next = rd_reg;
    nack_next = nack_reg; stop_next = stop_reg; rv_next = 1'b0;
    ack_next = ack_reg; rdy_next = rdy_reg;
    if (st_reg == see_pkg::SEM_IDLE && cmd_valid && rdy_reg) begin
      rdy_next = 1'b0; sh_next = cmd_data; rd_next = cmd_read;
      nack_next = cmd_nack; stop_next = cmd_stop; bit_next = 4'h0;
      phase_next = 1'b0; div_next = 9'h0;
      st_next = cmd_start ? see_pkg::SEM_START : see_pkg::SEM_BIT;
    end else if (tick) begin
      unique case (st_reg)
        see_pkg::SEM_START: begin
          if (!phase_reg) begin sda_next = 1'b1; scl_next = 1'b1; phase_next = 1'b1; end
          else begin sda_next = 1'b0; phase_next = 1'b0; st_next = see_pkg::SEM_BIT; end
        end
        see_pkg::SEM_BIT: begin
          if (!phase_reg) begin
            scl_next = 1'b0; phase_next = 1'b1;
          end else if (!scl_reg) begin
            sda_next = rd_reg ? 1'b1 : (bit_reg == 4'h8 ? 1'b1 : sh_reg[7]);
            if (bit_reg == 4'h8) sda_next = rd_reg ? nack_reg : 1'b1;
            scl_next = 1'b0;
            if (bit_reg != 4'hf) begin scl_next = 1'b1; end
          end else begin
            phase_next = 1'b0;
            if (bit_reg < 4'h8) sh_next = {sh_reg[6:0], sda_s2_reg};
            else ack_next = ~sda_s2_reg;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              rv_next = 1'b1; scl_next = 1'b0;
              st_next = stop_reg ? see_pkg::SEM_STOP : see_pkg::SEM_ACK;
            end
          end
        end
        see_pkg::SEM_STOP: begin
          if (!phase_reg) begin sda_next = 1'b0; scl_next = 1'b1; phase_next = 1'b1; end
          else begin sda_next = 1'b1; st_next = see_pkg::SEM_ACK; end
        end
        see_pkg::SEM_ACK: begin rdy_next = 1'b1; st_next = see_pkg::SEM_IDLE; end
        default: st_next = see_pkg::SEM_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= see_pkg::SEM_IDLE; div_reg <= 9'h0; phase_reg <= 1'b0;
      bit_reg <= 4'h0; sh_reg <= 8'h0; scl_reg <= 1'b1; sda_reg <= 1'b1;
      rd_reg <= 1'b0; nack_reg <= 1'b0; stop_reg <= 1'b0; rv_reg <= 1'b0;
      ack_reg <= 1'b0; rdy_reg <= 1'b1; sda_s1_reg <= 1'b1; sda_s2_reg <= 1'b1;
    end else begin
      st_reg <= st_next; div_reg <= div_next; phase_reg <= phase_next;
      bit_reg <= bit_next; sh_reg <= sh_next; scl_reg <= scl_next; sda_reg <= sda_next;
      rd_reg <= rd_next; nack_reg <= nack_next; stop_reg <= stop_next; rv_reg <= rv_next;
      ack_reg <= ack_next; rdy_reg <= rdy_next;
      sda_s1_reg <= bus.sda; sda_s2_reg <= sda_s1_reg;
    end
  end
  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe_n   = scl_reg;
  assign bus.sda_m_o    = 1'b0;
  assign bus.sda_m_oe_n = sda_reg;
  assign cmd_ready      = rdy_reg;
  assign rsp_valid      = rv_reg;
  assign rsp_data       = sh_reg;
  assign rsp_ack        = ack_reg;
endmodule

// file: see_bus_sva.sv
// Concurrent checks on the two-wire bus between the EEPROM slave and its master
module see_bus_sva #(
  parameter int PU_CYC = 100,
  parameter int WR_CYC = 200
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_s_o,
  input  wire logic sda_s_oe_n,
  input  wire logic ready,
  input  wire logic write_busy
);
  logic [15:0] pu_cnt_reg;
  logic [15:0] pu_cnt_next;
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;

  // Cycles since reset release, and length of the current internal write
  always_comb begin
    pu_cnt_next   = (pu_cnt_reg == 16'hffff) ? pu_cnt_reg : pu_cnt_reg + 16'h1;
    busy_cnt_next = write_busy ? busy_cnt_reg + 16'h1 : 16'h0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt_reg   <= 16'h0;
      busy_cnt_reg <= 16'h0;
    end else begin
      pu_cnt_reg   <= pu_cnt_next;
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  pull_only_low_a: assert property (!sda_s_oe_n |-> sda_s_o == 1'b0)
    else $error("slave drives the data line high");
  pull_in_low_a: assert property ($fell(sda_s_oe_n) |-> !scl)
    else $error("slave starts pulling data while clock is high");
  reset_quiet_a: assert property ($rose(reset_n) |-> !ready && !write_busy && sda_s_oe_n)
    else $error("slave not in standby after reset");
  ready_time_a: assert property (int'(pu_cnt_reg) == PU_CYC + 8 |-> ready)
    else $error("slave not ready after power-up delay");
  quiet_until_ready_a: assert property (!ready |-> sda_s_oe_n && !write_busy)
    else $error("slave active before ready");
  busy_silent_a: assert property (write_busy |-> sda_s_oe_n)
    else $error("slave drives data during internal write");
  busy_bound_a: assert property (int'(busy_cnt_reg) <= WR_CYC + 4)
    else $error("internal write runs too long");
  busy_full_a: assert property ($fell(write_busy) |-> int'(busy_cnt_reg) >= WR_CYC - 4)
    else $error("internal write ends too early");
  busy_on_stop_a: assert property ($rose(write_busy) |-> scl && sda)
    else $error("internal write starts without a stop");

  cover property ($rose(write_busy));
  cover property ($fell(write_busy));
  cover property ($fell(sda_s_oe_n) && ready);
endmodule

// file: serial_eeprom_bus_slave_tb.sv
// Self-checking bench joining the EEPROM slave and its bus master
module serial_eeprom_bus_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PU_CYC = 100;
  localparam int         WR_CYC = 10000;
  localparam logic [2:0] SEL    = 3'h5;
  localparam logic [7:0] ADDR_W = {see_pkg::TYPE_NIBBLE, SEL, 1'b0};
  localparam logic [7:0] ADDR_R = {see_pkg::TYPE_NIBBLE, SEL, 1'b1};
  logic       clk;
  logic       reset_n;
  logic [2:0] device_select_pins;
  logic       write_protect;
  logic       ready;
  logic       write_busy;
  logic       cmd_valid;
  logic       cmd_start;
  logic       cmd_stop;
  logic       cmd_read;
  logic       cmd_nack;
  logic [7:0] cmd_data;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_ack;
  int         n_errors;
  int         check_count;
  logic       ack;
  logic [7:0] q;

  see_bus_if see_bus_if_i ();
  see_slave #(.PU_CYC(PU_CYC), .WR_CYC(WR_CYC)) see_slave_i (
    .clk(clk), .reset_n(reset_n), .bus(see_bus_if_i.slave),
    .device_select_pins(device_select_pins), .write_protect(write_protect),
    .ready(ready), .write_busy(write_busy));
  see_master see_master_i (
    .clk(clk), .reset_n(reset_n), .bus(see_bus_if_i.master), .cmd_valid(cmd_valid),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  see_bus_sva #(.PU_CYC(PU_CYC), .WR_CYC(WR_CYC)) see_bus_sva_i (
    .clk(clk), .reset_n(reset_n), .scl(see_bus_if_i.scl), .sda(see_bus_if_i.sda),
    .sda_s_o(see_bus_if_i.sda_s_o), .sda_s_oe_n(see_bus_if_i.sda_s_oe_n),
    .ready(ready), .write_busy(write_busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait, bounded, until a flag reaches a level
  task automatic wait_for(ref logic sig, input logic lvl, input int limit);
    int n;
    n = 0;
    while (sig !== lvl && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // One byte through the master: offered for one clock once the master is ready, then wait for its answer
  task automatic send(input logic st, input logic sp, input logic rd, input logic nk,
                      input logic [7:0] d, output logic a, output logic [7:0] r);
    wait_for(cmd_ready, 1'b1, 40000);
    cmd_valid = 1'b1;
    cmd_start = st;
    cmd_stop  = sp;
    cmd_read  = rd;
    cmd_nack  = nk;
    cmd_data  = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    wait_for(rsp_valid, 1'b1, 20000);
    check_bit(rsp_valid, 1'b1);
    a = rsp_ack;
    r = rsp_data;
  endtask

  task automatic test_power_up();
    check_bit(ready, 1'b0);
    wait_for(ready, 1'b1, PU_CYC + 20);
    check_bit(ready, 1'b1);
    check_bit(see_bus_if_i.sda, 1'b1);
  endtask

  task automatic test_byte_write_and_poll();
    send(1'b1, 1'b0, 1'b0, 1'b0, ADDR_W, ack, q);
    check_bit(ack, 1'b1);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h03, ack, q);
    check_bit(ack, 1'b1);
    send(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a, ack, q);
    check_bit(ack, 1'b1);
    wait_for(write_busy, 1'b1, 2000);
    check_bit(write_busy, 1'b1);
    send(1'b1, 1'b1, 1'b0, 1'b0, ADDR_W, ack, q);
    check_bit(ack, 1'b0);
    wait_for(write_busy, 1'b0, WR_CYC + 100);
    check_bit(write_busy, 1'b0);
  endtask

  task automatic test_selective_read();
    send(1'b1, 1'b0, 1'b0, 1'b0, ADDR_W, ack, q);
    check_bit(ack, 1'b1);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h03, ack, q);
    check_bit(ack, 1'b1);
    send(1'b1, 1'b0, 1'b0, 1'b0, ADDR_R, ack, q);
    check_bit(ack, 1'b1);
    send(1'b0, 1'b1, 1'b1, 1'b1, 8'hff, ack, q);
    check_byte(q, 8'h5a);
  endtask

  task automatic test_wrong_select();
    send(1'b1, 1'b1, 1'b0, 1'b0, {see_pkg::TYPE_NIBBLE, ~SEL, 1'b0}, ack, q);
    check_bit(ack, 1'b0);
  endtask

  task automatic test_write_protect();
    write_protect = 1'b1;
    send(1'b1, 1'b0, 1'b0, 1'b0, ADDR_W, ack, q);
    check_bit(ack, 1'b1);
    send(1'b0, 1'b0, 1'b0, 1'b0, 8'h03, ack, q);
    check_bit(ack, 1'b1);
    send(1'b0, 1'b1, 1'b0, 1'b0, 8'h11, ack, q);
    check_bit(ack, 1'b0);
    wait_for(write_busy, 1'b1, 500);
    check_bit(write_busy, 1'b0);
    write_protect = 1'b0;
  endtask

  initial begin
    n_errors           = 0;
    check_count        = 0;
    reset_n            = 1'b0;
    device_select_pins = SEL;
    write_protect      = 1'b0;
    cmd_valid          = 1'b0;
    cmd_start          = 1'b0;
    cmd_stop           = 1'b0;
    cmd_read           = 1'b0;
    cmd_nack           = 1'b0;
    cmd_data           = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    test_power_up();
    test_byte_write_and_poll();
    test_selective_read();
    test_wrong_select();
    test_write_protect();
    complete_run();
  end

  // Watchdog just above the dozen bytes of bus traffic plus one internal write
  initial begin
    #980000;
    n_errors++;
    complete_run();
  end
endmodule
